// file: scep_params.svh
// constants for the serial config eeprom port: offsets, fields, resets, timing
`ifndef SCEP_PARAMS_SVH
`define SCEP_PARAMS_SVH

`define SCEP_WORD_BITS      16
`define SCEP_HDR_BITS       3
`define SCEP_DATA_POS       8
`define SCEP_DATA_BITS      8

// synchronised pin vector positions inside the device
`define SCEP_PIN_TEST       0
`define SCEP_PIN_SCLK       1
`define SCEP_PIN_SI         2
`define SCEP_PIN_EN         3
`define SCEP_PIN_VPP        4
`define SCEP_PIN_COUNT      5

// nonvolatile register addresses
`define SCEP_ADDR_LOOP      2'h0
`define SCEP_ADDR_POLE      2'h1

// loop_filter_drive_config fields
`define SCEP_ZERO_MSB       7
`define SCEP_ZERO_LSB       5
`define SCEP_COAST_BIT      4
`define SCEP_SYNC_BIT       3
`define SCEP_GAIN_MSB       2
`define SCEP_GAIN_LSB       0
// pole_and_speed_feedback_config fields
`define SCEP_POLE_MSB       7
`define SCEP_POLE_LSB       2
`define SCEP_FB_MSB         1
`define SCEP_FB_LSB         0

`define SCEP_LOOP_RESET     8'h88
`define SCEP_POLE_RESET     8'h71

// programmer apb register offsets
`define SCEP_OFF_CTRL       12'h000
`define SCEP_OFF_CMD        12'h004
`define SCEP_OFF_STATUS     12'h008
`define SCEP_CTRL_TEST_BIT  0
`define SCEP_CTRL_AUTO_BIT  1
`define SCEP_CMD_RD_BIT     2
`define SCEP_ST_BUSY_BIT    0
`define SCEP_ST_DONE_BIT    1

// timing
`define SCEP_CLK_HZ         20000000
`define SCEP_PROG_TIME_MS   5
`define SCEP_PROG_CYCLES    ((`SCEP_PROG_TIME_MS * `SCEP_CLK_HZ + 999) / 1000)
`define SCEP_SCLK_HALF      8

`endif

// file: scep_pkg.sv
// types shared by both ends of the serial config eeprom port
package scep_pkg;

    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [4:0]  s3;
        logic [4:0]  lvl;
        logic        armed;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic [1:0]  rd_addr;
        logic        rd_sel;
        logic [7:0]  rd_sh;
        logic        so;
        logic        hold_valid;
        logic [1:0]  hold_addr;
        logic        hold_rd;
        logic [7:0]  hold_data;
        logic [7:0]  nv0;
        logic [7:0]  nv1;
    } scep_dev_state_type;

    typedef enum logic [2:0] {
        SCEP_IDLE     = 3'b000,
        SCEP_SHIFT_LO = 3'b001,
        SCEP_SHIFT_HI = 3'b010,
        SCEP_TAIL     = 3'b011,
        SCEP_PROG     = 3'b100,
        SCEP_GAP      = 3'b101
    } scep_host_fsm_type;

    typedef struct packed {
        scep_host_fsm_type fsm;
        logic [7:0]  div;
        logic [4:0]  bit_cnt;
        logic [23:0] prog_cnt;
        logic [15:0] word;
        logic        rd_cmd;
        logic [7:0]  rdata;
        logic        done;
        logic        test;
        logic        auto_prog;
        logic        sclk;
        logic        en;
        logic        si;
        logic        vpp;
        logic        so_s1;
        logic        so_s2;
        logic        so_s3;
        logic        so_lvl;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } scep_host_state_type;

endpackage

// file: scep_link_if.sv
// serial test pins joining the programmer and the device
`timescale 1ns/1ps
interface scep_link_if;
    logic test_mode;
    logic shift_clk;
    logic serial_in;
    logic transfer_enable_pin;
    logic prog_strobe;
    logic serial_out;
    logic serial_out_oe;
    wire  serial_out_line;

    // undriven output line reads low
    assign serial_out_line = serial_out_oe ? serial_out : 1'b0;

    modport device (
        input  test_mode,
        input  shift_clk,
        input  serial_in,
        input  transfer_enable_pin,
        input  prog_strobe,
        output serial_out,
        output serial_out_oe
    );

    modport programmer (
        output test_mode,
        output shift_clk,
        output serial_in,
        output transfer_enable_pin,
        output prog_strobe,
        input  serial_out_line
    );
endinterface

// file: scep_device.sv
// device end: serial test port and the two nonvolatile configuration registers
`timescale 1ns/1ps
`include "scep_params.svh"

module scep_device
    import scep_pkg::*;
#(
    parameter logic [7:0] LOOP_RESET = `SCEP_LOOP_RESET,
    parameter logic [7:0] POLE_RESET = `SCEP_POLE_RESET
)
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    scep_link_if.device link,
    output logic        serial_mode,
    output logic [2:0]  filter_zero_coefficient,
    output logic        coast_enable,
    output logic        sync_rectify_enable,
    output logic [2:0]  integrator_gain_sel,
    output logic [5:0]  filter_pole_coefficient,
    output logic [1:0]  speed_feedback_freq_sel,
    output logic [7:0]  loop_filter_drive_config,
    output logic [7:0]  pole_and_speed_feedback_config
);

    scep_dev_state_type q;
    scep_dev_state_type d;
    logic [4:0]         pins;
    logic [4:0]         rise;
    logic [4:0]         fall;
    logic               mode;
    logic [4:0]         lvl_next;
    logic [7:0]         rd_byte;
    logic               word_full;
    logic               sclk_step;
    logic               data_phase;

    // pin vector in synchroniser order
    assign pins[`SCEP_PIN_TEST] = link.test_mode;
    assign pins[`SCEP_PIN_SCLK] = link.shift_clk;
    assign pins[`SCEP_PIN_SI]   = link.serial_in;
    assign pins[`SCEP_PIN_EN]   = link.transfer_enable_pin;
    assign pins[`SCEP_PIN_VPP]  = link.prog_strobe;

    // per pin: a level moves only once stages two and three agree
    for (genvar g = 0; g < `SCEP_PIN_COUNT; g++)
    begin : g_pin
        assign lvl_next[g] = (q.s2[g] == q.s3[g]) ? q.s2[g] : q.lvl[g];
        assign rise[g]     = lvl_next[g] && !q.lvl[g];
        assign fall[g]     = !lvl_next[g] && q.lvl[g];
    end

    always_comb
    begin
        d    = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = lvl_next;
        mode  = q.lvl[`SCEP_PIN_TEST];

        // a word counts only at exactly sixteen rises
        word_full  = (q.cnt == 5'(`SCEP_WORD_BITS));
        // shifting stops at a full word until the next enable rise
        sclk_step  = rise[`SCEP_PIN_SCLK] && q.armed && q.lvl[`SCEP_PIN_EN]
                     && !word_full;
        // readout bits follow the header and filler
        data_phase = (q.cnt >= 5'(`SCEP_DATA_POS))
                     && (q.cnt < 5'(`SCEP_WORD_BITS - 1));

        // addresses two and three read back as zero
        unique case (q.rd_addr)
            `SCEP_ADDR_LOOP: rd_byte = q.nv0;
            `SCEP_ADDR_POLE: rd_byte = q.nv1;
            default:         rd_byte = 8'h00;
        endcase

        if (!mode)
        begin
            // outside test mode the port is dead
            d.armed      = 1'b0;
            d.so         = 1'b0;
            d.hold_valid = 1'b0;
        end
        else
        begin
            if (rise[`SCEP_PIN_EN])
            begin
                // a new word discards any held, uncommitted word
                d.armed      = 1'b1;
                d.cnt        = 5'h00;
                d.rd_sel     = 1'b0;
                d.so         = 1'b0;
                d.hold_valid = 1'b0;
            end
            else if (fall[`SCEP_PIN_EN])
            begin
                d.armed      = 1'b0;
                // only a full word settles into the holding register
                d.hold_valid = q.armed && word_full;
                d.hold_addr  = q.sh[1:0];
                d.hold_rd    = q.sh[`SCEP_HDR_BITS-1];
                d.hold_data  = q.sh[`SCEP_WORD_BITS-1:`SCEP_DATA_POS];
                d.so         = 1'b0;
            end
            else if (sclk_step)
            begin
                // lsb first: the first bit ends at sh[0]
                d.sh  = {q.lvl[`SCEP_PIN_SI], q.sh[15:1]};
                d.cnt = q.cnt + 5'h01;
                // header complete: keep address and direction for readout
                if (q.cnt == 5'(`SCEP_HDR_BITS - 1))
                begin
                    d.rd_addr = q.sh[15:14];
                    d.rd_sel  = q.lvl[`SCEP_PIN_SI];
                end
                if (q.cnt == 5'(`SCEP_DATA_POS - 1))
                begin
                    if (q.rd_sel)
                    begin
                        // current contents at the time of the read
                        d.so    = rd_byte[0];
                        d.rd_sh = {1'b0, rd_byte[7:1]};
                    end
                end
                else if (data_phase)
                begin
                    d.so    = q.rd_sh[0];
                    d.rd_sh = {1'b0, q.rd_sh[7:1]};
                end
                else
                begin
                    // header, filler and the last rise drive zero
                    d.so = 1'b0;
                end
            end
            if (rise[`SCEP_PIN_VPP] && q.hold_valid)
            begin
                // the held word is spent by one strobe
                d.hold_valid = 1'b0;
                if (!q.hold_rd)
                begin
                    if (q.hold_addr == `SCEP_ADDR_LOOP)
                    begin
                        d.nv0 = q.hold_data;
                    end
                    if (q.hold_addr == `SCEP_ADDR_POLE)
                    begin
                        d.nv1 = q.hold_data;
                    end
                end
            end
        end
    end

    // nonvolatile contents come up at their default values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q     <= '0;
            q.nv0 <= LOOP_RESET;
            q.nv1 <= POLE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign serial_mode        = q.lvl[`SCEP_PIN_TEST];
    assign link.serial_out    = q.so;
    // output line driven only while test mode is seen
    assign link.serial_out_oe = q.lvl[`SCEP_PIN_TEST];

    // exactly two registers, decoded into their fields
    assign loop_filter_drive_config       = q.nv0;
    assign pole_and_speed_feedback_config = q.nv1;
    assign filter_zero_coefficient = q.nv0[`SCEP_ZERO_MSB:`SCEP_ZERO_LSB];
    assign coast_enable            = q.nv0[`SCEP_COAST_BIT];
    assign sync_rectify_enable     = q.nv0[`SCEP_SYNC_BIT];
    assign integrator_gain_sel     = q.nv0[`SCEP_GAIN_MSB:`SCEP_GAIN_LSB];
    assign filter_pole_coefficient = q.nv1[`SCEP_POLE_MSB:`SCEP_POLE_LSB];
    assign speed_feedback_freq_sel = q.nv1[`SCEP_FB_MSB:`SCEP_FB_LSB];

endmodule

// file: scep_programmer.sv
// programmer end: apb command registers driving the serial test pins
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "scep_params.svh"

module scep_programmer
    import scep_pkg::*;
#(
    parameter int SCLK_HALF   = `SCEP_SCLK_HALF,
    parameter int PROG_CYCLES = `SCEP_PROG_CYCLES
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]     prdata,
    output logic            pready,
    output logic            pslverr,
    scep_link_if.programmer link
);

    scep_host_state_type q;
    scep_host_state_type d;
    logic                wr;
    logic                half_end;

    always_comb
    begin
        d        = q;
        d.so_s1  = link.serial_out_line;
        d.so_s2  = q.so_s1;
        d.so_s3  = q.so_s2;
        d.so_lvl = (q.so_s2 == q.so_s3) ? q.so_s2 : q.so_lvl;
        half_end = (q.div == 8'(SCLK_HALF - 1));
        d.div    = half_end ? 8'h00 : q.div + 8'h01;
        wr       = psel && penable && q.pready && pwrite && !q.pslverr;
        // apb: answer prepared in setup, taken in the one access cycle
        d.pready  = psel && !penable;
        d.pslverr = 1'b0;
        d.prdata  = 32'h0000_0000;
        if (psel && !penable)
        begin
            unique case (paddr)
                `SCEP_OFF_CTRL:   d.prdata = {30'h0, q.auto_prog, q.test};
                `SCEP_OFF_CMD:    d.prdata = {16'h0, q.word[15:8], 5'h00,
                                              q.rd_cmd, q.word[1:0]};
                `SCEP_OFF_STATUS: d.prdata = {16'h0, q.rdata, 6'h00, q.done,
                                              (q.fsm != SCEP_IDLE)};
                default:          d.pslverr = 1'b1;
            endcase
        end
        if (wr && (paddr == `SCEP_OFF_CTRL))
        begin
            d.test      = pwdata[`SCEP_CTRL_TEST_BIT];
            d.auto_prog = pwdata[`SCEP_CTRL_AUTO_BIT];
        end
        unique case (q.fsm)
            SCEP_IDLE:
            begin
                if (wr && (paddr == `SCEP_OFF_CMD))
                begin
                    // one 16-bit word, zero filler, zero data on reads
                    d.rd_cmd = pwdata[`SCEP_CMD_RD_BIT];
                    d.word   = {(pwdata[`SCEP_CMD_RD_BIT] ? 8'h00 : pwdata[15:8]),
                                5'h00, pwdata[`SCEP_CMD_RD_BIT], pwdata[1:0]};
                    d.si      = pwdata[0];
                    d.en      = 1'b1;
                    d.sclk    = 1'b0;
                    d.bit_cnt = 5'h00;
                    d.div     = 8'h00;
                    d.done    = 1'b0;
                    d.fsm     = SCEP_SHIFT_LO;
                end
            end
            SCEP_SHIFT_LO:
            begin
                if (half_end)
                begin
                    if (q.bit_cnt == 5'(`SCEP_WORD_BITS))
                    begin
                        d.en  = 1'b0;
                        d.fsm = SCEP_TAIL;
                    end
                    else
                    begin
                        if (q.bit_cnt >= 5'(`SCEP_DATA_POS))
                        begin
                            d.rdata = {q.so_lvl, q.rdata[7:1]};
                        end
                        d.sclk = 1'b1;
                        d.fsm  = SCEP_SHIFT_HI;
                    end
                end
            end
            SCEP_SHIFT_HI:
            begin
                if (half_end)
                begin
                    d.sclk    = 1'b0;
                    d.bit_cnt = q.bit_cnt + 5'h01;
                    d.word    = {1'b0, q.word[15:1]};
                    d.si      = q.word[1];
                    d.fsm     = SCEP_SHIFT_LO;
                end
            end
            SCEP_TAIL:
            begin
                if (half_end)
                begin
                    if (q.auto_prog && !q.rd_cmd)
                    begin
                        d.vpp      = 1'b1;
                        d.prog_cnt = 24'h000000;
                        d.fsm      = SCEP_PROG;
                    end
                    else
                    begin
                        d.done = 1'b1;
                        d.fsm  = SCEP_IDLE;
                    end
                end
            end
            SCEP_PROG:
            begin
                d.prog_cnt = q.prog_cnt + 24'h000001;
                if (q.prog_cnt == 24'(PROG_CYCLES - 1))
                begin
                    d.vpp = 1'b0;
                    d.div = 8'h00;
                    d.fsm = SCEP_GAP;
                end
            end
            SCEP_GAP:
            begin
                if (half_end)
                begin
                    d.done = 1'b1;
                    d.fsm  = SCEP_IDLE;
                end
            end
            default:
            begin
                d.fsm = SCEP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q     <= '0;
            q.fsm <= SCEP_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata                   = q.prdata;
    assign pready                   = q.pready;
    assign pslverr                  = q.pslverr;
    assign link.test_mode           = q.test;
    assign link.shift_clk           = q.sclk;
    assign link.serial_in           = q.si;
    assign link.transfer_enable_pin = q.en;
    assign link.prog_strobe         = q.vpp;

endmodule

// file: scep_link_sva.sv
// assertions on the serial test pins between programmer and device
`timescale 1ns/1ps
`include "scep_params.svh"
module scep_link_sva
#(
    parameter int PROG_CYCLES = `SCEP_PROG_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic test_mode,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic transfer_enable_pin,
    input wire logic prog_strobe,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic [4:0]  rise_cnt_q;
    logic        rd_q;
    logic        sclk_q;
    logic        en_q;
    logic [3:0]  age_q;
    logic [23:0] vpp_len_q;

    // shift clock rises counted per word, header read bit kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rise_cnt_q <= 5'h0;
            rd_q <= 1'b0;
            sclk_q <= 1'b0;
            en_q <= 1'b0;
            age_q <= 4'hF;
            vpp_len_q <= 24'h0;
        end
        else
        begin
            sclk_q <= shift_clk;
            en_q <= transfer_enable_pin;
            vpp_len_q <= prog_strobe ? vpp_len_q + 24'h1 : 24'h0;
            if (transfer_enable_pin && !en_q)
                rise_cnt_q <= 5'h0;
            else if (shift_clk && !sclk_q && transfer_enable_pin)
                rise_cnt_q <= rise_cnt_q + 5'h1;
            if (shift_clk && !sclk_q)
                age_q <= 4'h0;
            else if (age_q != 4'hF)
                age_q <= age_q + 4'h1;
            if (shift_clk && !sclk_q && rise_cnt_q == 5'h2)
                rd_q <= serial_in;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_sclk_rise;
        $rose(shift_clk);
    endsequence
    sequence s_word_end;
        $fell(transfer_enable_pin);
    endsequence

    property p_oe_on;
        $rose(test_mode) |-> ##[1:8] serial_out_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("output enable did not follow test mode");
    property p_out_idle;
        !test_mode [*8] |-> !serial_out_oe && !serial_out;
    endproperty
    a_out_idle: assert property (p_out_idle)
        else $error("serial output active outside test mode");
    property p_sclk_en;
        s_sclk_rise |-> transfer_enable_pin;
    endproperty
    a_sclk_en: assert property (p_sclk_en)
        else $error("shift clock rose outside a word");
    property p_si_stable;
        s_sclk_rise |-> $stable(serial_in);
    endproperty
    a_si_stable: assert property (p_si_stable)
        else $error("serial input moved at shift clock rise");
    property p_hdr_zero;
        s_sclk_rise ##0 (rise_cnt_q >= 5'h3 && rise_cnt_q <= 5'h7) |-> !serial_in;
    endproperty
    a_hdr_zero: assert property (p_hdr_zero)
        else $error("padding bit not zero");
    property p_rd_zero;
        s_sclk_rise ##0 (rd_q && rise_cnt_q >= 5'h8) |-> !serial_in;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("data bit not zero in read word");
    property p_word_len;
        s_word_end |-> rise_cnt_q == 5'h10;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("word did not hold sixteen clocks");
    property p_strobe_after;
        $rose(prog_strobe) |-> !transfer_enable_pin && rise_cnt_q == 5'h10 && !rd_q;
    endproperty
    a_strobe_after: assert property (p_strobe_after)
        else $error("program strobe rose out of place");
    property p_strobe_len;
        $fell(prog_strobe) |-> vpp_len_q >= PROG_CYCLES;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("program strobe too short");
    property p_so_tail;
        s_sclk_rise ##0 (rise_cnt_q == 5'hF && test_mode) |-> ##[1:8] !serial_out;
    endproperty
    a_so_tail: assert property (p_so_tail)
        else $error("serial output not cleared after last bit");
    property p_so_step;
        test_mode && transfer_enable_pin && $changed(serial_out) |-> age_q <= 4'h8;
    endproperty
    a_so_step: assert property (p_so_step)
        else $error("serial output moved away from a clock rise");
endmodule

// file: serial_config_eeprom_port_test.sv
// self-checking bench: programmer and device joined over the serial pins
`timescale 1ns/1ps
`include "scep_params.svh"
module serial_config_eeprom_port_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        serial_mode;
    logic [2:0]  filter_zero_coefficient;
    logic        coast_enable;
    logic        sync_rectify_enable;
    logic [2:0]  integrator_gain_sel;
    logic [5:0]  filter_pole_coefficient;
    logic [1:0]  speed_feedback_freq_sel;
    logic [7:0]  loop_cfg;
    logic [7:0]  pole_cfg;
    int          fails;
    int          samples_checked;
    int          seed;
    int          i;
    logic [7:0]  exp_reg [2];
    logic [7:0]  corners [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
    logic [31:0] q;
    logic [31:0] st;
    logic        e;
    logic [1:0]  a;
    logic [7:0]  d;

    scep_link_if scep_link_if_inst ();
    scep_programmer #(.SCLK_HALF(8), .PROG_CYCLES(20)) scep_programmer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(scep_link_if_inst));
    scep_device scep_device_inst (
        .pclk(pclk), .presetn(presetn), .link(scep_link_if_inst),
        .serial_mode(serial_mode), .filter_zero_coefficient(filter_zero_coefficient),
        .coast_enable(coast_enable), .sync_rectify_enable(sync_rectify_enable),
        .integrator_gain_sel(integrator_gain_sel),
        .filter_pole_coefficient(filter_pole_coefficient),
        .speed_feedback_freq_sel(speed_feedback_freq_sel),
        .loop_filter_drive_config(loop_cfg), .pole_and_speed_feedback_config(pole_cfg));
    scep_link_sva #(.PROG_CYCLES(20)) scep_link_sva_inst (
        .pclk(pclk), .presetn(presetn), .test_mode(scep_link_if_inst.test_mode),
        .shift_clk(scep_link_if_inst.shift_clk), .serial_in(scep_link_if_inst.serial_in),
        .transfer_enable_pin(scep_link_if_inst.transfer_enable_pin),
        .prog_strobe(scep_link_if_inst.prog_strobe),
        .serial_out(scep_link_if_inst.serial_out),
        .serial_out_oe(scep_link_if_inst.serial_out_oe));

    always #25 pclk = ~pclk;

    function automatic logic [31:0] cmd_word(logic [1:0] ad, logic rd, logic [7:0] dt);
        return {16'h0, dt, 5'h0, rd, ad};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] want, input string what);
        samples_checked++;
        if (got !== want)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] dt,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= dt;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1, "apb answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task word(input logic [1:0] ad, input logic rd, input logic [7:0] dt);
        int n;
        apb(1'b1, `SCEP_OFF_CMD, cmd_word(ad, rd, dt), q, e);
        chk({31'h0, e}, 32'h0, "command error");
        apb(1'b0, `SCEP_OFF_STATUS, 32'h0, st, e);
        chk({31'h0, st[`SCEP_ST_BUSY_BIT]}, 32'h1, "busy during word");
        n = 0;
        do
        begin
            apb(1'b0, `SCEP_OFF_STATUS, 32'h0, st, e);
            n++;
        end
        while (st[`SCEP_ST_DONE_BIT] !== 1'b1 && n < 400);
        chk({31'h0, st[`SCEP_ST_DONE_BIT]}, 32'h1, "word finished");
        chk({31'h0, st[`SCEP_ST_BUSY_BIT]}, 32'h0, "idle after word");
    endtask

    task regs(input string what);
        chk({24'h0, loop_cfg}, {24'h0, exp_reg[0]}, "register 0");
        chk({24'h0, pole_cfg}, {24'h0, exp_reg[1]}, "register 1");
        chk({24'h0, filter_zero_coefficient, coast_enable, sync_rectify_enable,
             integrator_gain_sel}, {24'h0, exp_reg[0]}, "fields 0");
        chk({24'h0, filter_pole_coefficient, speed_feedback_freq_sel},
            {24'h0, exp_reg[1]}, "fields 1");
        $display("test %s done", what);
    endtask

    task final_report;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        samples_checked = 0;
        seed = 32'hc9d0;
        exp_reg[0] = `SCEP_LOOP_RESET;
        exp_reg[1] = `SCEP_POLE_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, serial_mode}, 32'h0, "mode after reset");
        regs("reset");
        // full write sequence with test mode off changes nothing
        apb(1'b1, `SCEP_OFF_CTRL, 32'h2, q, e);
        word(2'h0, 1'b0, 8'h3C);
        regs("no test mode");
        apb(1'b1, `SCEP_OFF_CTRL, 32'h1, q, e);
        repeat (8) @(posedge pclk);
        chk({31'h0, serial_mode}, 32'h1, "mode entered");
        // word sent without program strobe is not committed
        word(2'h1, 1'b0, 8'h55);
        regs("no strobe");
        apb(1'b1, `SCEP_OFF_CTRL, 32'h3, q, e);
        apb(1'b0, `SCEP_OFF_CTRL, 32'h0, q, e);
        chk(q, 32'h3, "control read back");
        word(2'h2, 1'b0, 8'hA5);
        regs("address two");
        for (i = 0; i < 12; i++)
        begin
            a = {1'b0, 1'($random(seed))};
            d = (i < 4) ? corners[i] : 8'($random(seed));
            word(a, 1'b0, d);
            exp_reg[a[0]] = d;
            regs("write");
            word(a, 1'b1, 8'h00);
            chk({24'h0, st[15:8]}, {24'h0, exp_reg[a[0]]}, "read back");
            regs("read");
        end
        apb(1'b0, 12'h0FC, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        $display("test unmapped done");
        apb(1'b1, `SCEP_OFF_CTRL, 32'h0, q, e);
        repeat (8) @(posedge pclk);
        chk({31'h0, serial_mode}, 32'h0, "mode left");
        regs("exit");
        final_report;
    end

    initial
    begin
        repeat (40000) @(posedge pclk);
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report;
    end
endmodule
